// ===== voice_port_pkg.sv
// Constants, types and rule summary for the slave voice serial port
// Operation
// RQ1 - Codec drives bit clock and strobe; inputs
// RQ2 - Slave when clock mode 0, enabled, port 1
// RQ3 - Normal edge 0: transmit on falling edges
// RQ4 - Normal edge 0: capture on rising edges
// RQ5 - Sample rate fixed at 8 kHz
// RQ6 - Normal example uses 24-bit channel slots
// RQ7 - Codec supplies 384 kHz for 24-bit stereo
// RQ8 - Dual mono: same word in both slots
// RQ9 - Normal: slots alternate by strobe level
// RQ10 - One master; one driver per data line
// RQ11 - Burst: 16 data bits, 32 discarded bits
// RQ12 - Burst: launch rising, sample falling always
// RQ13 - Burst receiver latches on falling edges
// RQ14 - Burst format offered only as slave
// RQ15 - Normal strobe selects left or right channel
// RQ16 - Burst strobe marks frame start
// RQ17 - Normal edge 1: launch rising, sample falling
// RQ18 - MSB first, fixed offset from strobe edge
package voice_port_pkg;
   // Register byte offsets
   localparam logic [3:0] CTRL_OFS   = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] TXW_OFS    = 4'h8;
   localparam logic [3:0] RXW_OFS    = 4'hc;
   // Control field positions
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_PORT_LSB  = 1;
   localparam int CTRL_CLKM_BIT  = 3;
   localparam int CTRL_FMT_BIT   = 4;
   localparam int CTRL_WID_LSB   = 5;
   localparam int CTRL_EDGE_BIT  = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
   // Setting codes
   localparam logic [1:0] PORT_ONE  = 2'h1;
   localparam logic       CLKM_SLV  = 1'b0;
   localparam logic       FMT_BURST = 1'b0;
   localparam logic       FMT_NORM  = 1'b1;
   localparam logic [2:0] WID_16    = 3'h0;
   localparam logic [2:0] WID_24    = 3'h3;
   localparam logic [2:0] WID_32    = 3'h4;
   // Frame figures
   localparam int SAMPLE_RATE_HZ = 8000;
   localparam int BURST_DATA_BITS = 16;
   localparam int BURST_DISC_BITS = 32;
   localparam int BURST_FRAME_BITS = BURST_DATA_BITS + BURST_DISC_BITS;
   localparam int BIT_CLK_HZ = BURST_FRAME_BITS * SAMPLE_RATE_HZ;
   localparam logic [5:0] LAUNCH_OFFSET = 6'h00;
   // Sync stages and buffer depth
   localparam int SYNC_STAGES = 2;
   localparam int BUF_DEPTH = 2;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_SKIP  = 2'b10
   } rx_state_t;

   typedef struct packed
   {
      logic       edge_sel;
      logic [2:0] width;
      logic       fmt;
      logic       clk_mode;
      logic [1:0] port;
      logic       enable;
   } port_cfg_t;
endpackage

// ===== voice_serial_port_slave.sv
// Slave voice serial port with classic Wishbone register access
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
module voice_serial_port_slave
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        bit_clk,
   input  wire logic        word_align_strobe,
   input  wire logic        serial_rx,
   output logic             serial_tx,
   output logic             serial_tx_oe
);
   // Synchronisers for the codec pins
   logic [1:0] sclk_s_q, sclk_s_d;
   logic [1:0] strb_s_q, strb_s_d;
   logic [1:0] rxd_s_q, rxd_s_d;
   logic       sclk_old_q, sclk_old_d;
   logic       strb_old_q, strb_old_d;
   // Register state
   voice_port_pkg::port_cfg_t cfg_q, cfg_d;
   logic [31:0] txw_q, txw_d;
   logic [31:0] rxw_q, rxw_d;
   logic        rx_new_q, rx_new_d;
   logic        ovf_q, ovf_d;
   logic        ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   // Serial engine state
   voice_port_pkg::rx_state_t st_q, st_d;
   logic [5:0]  cnt_q, cnt_d;
   logic [31:0] sh_rx_q, sh_rx_d;
   logic [31:0] sh_tx_q, sh_tx_d;
   logic        tx_q, tx_d;
   logic        oe_q, oe_d;
   // Two-entry receive buffer
   logic [31:0] buf_q [voice_port_pkg::BUF_DEPTH];
   logic [31:0] buf_d [voice_port_pkg::BUF_DEPTH];
   logic [1:0]  fill_q, fill_d;

   // Edge and mode decode
   logic       rise;       // Synced bit clock rose
   logic       fall;       // Synced bit clock fell
   logic       strb_edge;  // Strobe changed level
   logic       strb_rise;  // Strobe rose
   logic       active;     // Slave port enabled
   logic       burst;      // Burst format selected
   logic       launch;     // Edge that moves tx
   logic       sample;     // Edge that captures rx
   logic       in_valid;   // Received word complete
   logic       in_ready;   // Buffer has a free entry
   logic       out_valid;  // Buffer holds a word
   logic       out_ready;  // Bus pops the oldest word
   logic       wr;         // Bus write taken
   logic       rd;         // Bus read taken
   logic [6:0] nbits;      // Bits per slot, up to 32
   assign rise      = sclk_s_q[1] & ~sclk_old_q;
   assign fall      = ~sclk_s_q[1] & sclk_old_q;
   assign strb_edge = strb_s_q[1] ^ strb_old_q;
   assign strb_rise = strb_s_q[1] & ~strb_old_q;
   // Slave only with clock mode 0, enabled, port 1
   assign active = cfg_q.enable & (cfg_q.clk_mode == voice_port_pkg::CLKM_SLV)
                   & (cfg_q.port == voice_port_pkg::PORT_ONE); // RQ2 RQ1 RQ14
   assign burst  = (cfg_q.fmt == voice_port_pkg::FMT_BURST);
   // Burst ignores edge setting; normal edge 0 launches falling
   assign launch = (burst | cfg_q.edge_sel) ? rise : fall; // RQ3 RQ12 RQ17
   assign sample = (burst | cfg_q.edge_sel) ? fall : rise; // RQ4 RQ13 RQ17
   assign nbits  = burst ? 7'(voice_port_pkg::BURST_DATA_BITS) :
                   (cfg_q.width == voice_port_pkg::WID_32) ? 7'd32 :
                   (cfg_q.width == voice_port_pkg::WID_24) ? 7'd24 : 7'd16; // RQ6 RQ11
   // Requests are taken only while ack is low
   assign wr = wb_cyc_i & wb_stb_i & ~ack_q & wb_we_i;
   assign rd = wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i;
   // Buffer handshake on both sides
   assign out_valid = (fill_q != 2'h0);
   assign out_ready = rd & (wb_adr_i == voice_port_pkg::RXW_OFS);
   assign in_ready  = (fill_q != 2'h2);

   // Pin synchronisers and edge history
   always_comb
   begin
      sclk_s_d   = {sclk_s_q[0], bit_clk};
      strb_s_d   = {strb_s_q[0], word_align_strobe};
      rxd_s_d    = {rxd_s_q[0], serial_rx};
      sclk_old_d = sclk_s_q[1];
      strb_old_d = strb_s_q[1];
   end

   // Serial engine: frame alignment, shift, slot repeat
   always_comb
   begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      sh_rx_d = sh_rx_q;
      sh_tx_d = sh_tx_q;
      tx_d    = tx_q;
      oe_d    = active; // RQ10
      in_valid = 1'b0;
      if (!active)
      begin
         st_d = voice_port_pkg::ST_IDLE;
         tx_d = 1'b0;
      end
      else
      begin
         // Burst frame starts on strobe rise; normal slot on either edge
         // No rate setting: the codec's strobe paces every frame
         if ((burst ? strb_rise : strb_edge) && launch) // RQ16 RQ15 RQ9 RQ5
         begin
            st_d    = voice_port_pkg::ST_SHIFT;
            cnt_d   = voice_port_pkg::LAUNCH_OFFSET;
            sh_tx_d = txw_q << (7'd32 - nbits);  // RQ8 RQ18
            tx_d    = txw_q[5'(nbits - 7'd1)];   // RQ18
         end
         else if (st_q == voice_port_pkg::ST_SHIFT && launch && cnt_q != 6'h00)
         begin
            sh_tx_d = {sh_tx_q[30:0], 1'b0};
            tx_d    = sh_tx_q[30];
         end
         if (st_q == voice_port_pkg::ST_SHIFT && sample)
         begin
            sh_rx_d = {sh_rx_q[30:0], rxd_s_q[1]};
            cnt_d   = cnt_q + 6'h01;
            if ({1'b0, cnt_q} == nbits - 7'h01)
            begin
               in_valid = 1'b1;
               // Burst discards trailing bits until next frame
               st_d = burst ? voice_port_pkg::ST_SKIP : voice_port_pkg::ST_IDLE; // RQ11
            end
         end
      end
   end

   // Receive buffer push and pop
   always_comb
   begin
      buf_d  = buf_q;
      fill_d = fill_q;
      ovf_d  = ovf_q;
      // Software clear first, so that a loss in the same cycle wins
      if (wr && wb_adr_i == voice_port_pkg::STATUS_OFS && wb_dat_i[2])
         ovf_d = 1'b0;
      if (out_valid && out_ready)
      begin
         buf_d[0] = buf_q[1];
         fill_d   = fill_q - 2'h1;
      end
      if (in_valid)
      begin
         if (in_ready || (out_valid && out_ready))
         begin
            buf_d[fill_d[0]] = sh_rx_d & ((32'h1 << nbits) - 32'h1);
            fill_d = fill_d + 2'h1;
         end
         else
            ovf_d = 1'b1; // Word lost: buffer full
      end
   end

   // Wishbone registers
   always_comb
   begin
      cfg_d    = cfg_q;
      txw_d    = txw_q;
      rxw_d    = rxw_q;
      rx_new_d = rx_new_q;
      ack_d    = wb_cyc_i & wb_stb_i & ~ack_q;
      dat_d    = 32'h0;
      if (wr && wb_adr_i == voice_port_pkg::CTRL_OFS && wb_sel_i[0])
         cfg_d = wb_dat_i[8:0];
      else if (wr && wb_adr_i == voice_port_pkg::CTRL_OFS && wb_sel_i[1])
         cfg_d.edge_sel = wb_dat_i[voice_port_pkg::CTRL_EDGE_BIT];
      else if (wr && wb_adr_i == voice_port_pkg::TXW_OFS)
      begin
         for (int i = 0; i < 4; i++)
            if (wb_sel_i[i])
               txw_d[i*8 +: 8] = wb_dat_i[i*8 +: 8];
      end
      if (rd)
      begin
         if (wb_adr_i == voice_port_pkg::CTRL_OFS)
            dat_d = {23'h0, cfg_q};
         else if (wb_adr_i == voice_port_pkg::STATUS_OFS)
            dat_d = {27'h0, fill_q, ovf_q, active, out_valid};
         else if (wb_adr_i == voice_port_pkg::TXW_OFS)
            dat_d = txw_q;
         else if (wb_adr_i == voice_port_pkg::RXW_OFS)
            dat_d = out_valid ? buf_q[0] : 32'h0;
         else
            dat_d = 32'h0;
      end
      rx_new_d = out_valid;
      rxw_d    = buf_q[0];
   end

   // State registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_s_q   <= 2'h0;
         strb_s_q   <= 2'h0;
         rxd_s_q    <= 2'h0;
         sclk_old_q <= 1'b0;
         strb_old_q <= 1'b0;
         cfg_q      <= voice_port_pkg::CTRL_RESET[8:0];
         txw_q      <= 32'h0;
         rxw_q      <= 32'h0;
         rx_new_q   <= 1'b0;
         ovf_q      <= 1'b0;
         ack_q      <= 1'b0;
         dat_q      <= 32'h0;
         st_q       <= voice_port_pkg::ST_IDLE;
         cnt_q      <= 6'h00;
         sh_rx_q    <= 32'h0;
         sh_tx_q    <= 32'h0;
         tx_q       <= 1'b0;
         oe_q       <= 1'b0;
         fill_q     <= 2'h0;
         buf_q[0]   <= 32'h0;
         buf_q[1]   <= 32'h0;
      end
      else if (clk_en)
      begin
         sclk_s_q   <= sclk_s_d;
         strb_s_q   <= strb_s_d;
         rxd_s_q    <= rxd_s_d;
         sclk_old_q <= sclk_old_d;
         strb_old_q <= strb_old_d;
         cfg_q      <= cfg_d;
         txw_q      <= txw_d;
         rxw_q      <= rxw_d;
         rx_new_q   <= rx_new_d;
         ovf_q      <= ovf_d;
         ack_q      <= ack_d;
         dat_q      <= dat_d;
         st_q       <= st_d;
         cnt_q      <= cnt_d;
         sh_rx_q    <= sh_rx_d;
         sh_tx_q    <= sh_tx_d;
         tx_q       <= tx_d;
         oe_q       <= oe_d;
         fill_q     <= fill_d;
         buf_q      <= buf_d;
      end
   end

   // Outputs straight from their registers
   assign wb_dat_o     = dat_q;
   assign wb_ack_o     = ack_q;
   assign serial_tx    = tx_q;
   assign serial_tx_oe = oe_q;

   // Checks
   chk_ack_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && ack_q |=> !ack_q) else $error("ack held too long");
   chk_oe_follows_slave: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
      clk_en && !active |=> !serial_tx_oe) else $error("tx driven while not slave");
   chk_tx_change_edge: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
      clk_en && active && !burst && !cfg_q.edge_sel && !fall && $stable(cfg_q)
      |=> $stable(serial_tx)) else $error("tx moved off falling edge");
   chk_burst_tx_edge: assert property (@(posedge mclk) disable iff (!rst_n) // RQ12
      clk_en && active && burst && !rise && $stable(cfg_q)
      |=> $stable(serial_tx)) else $error("burst tx moved off rising edge");
   chk_edge1_tx: assert property (@(posedge mclk) disable iff (!rst_n) // RQ17
      clk_en && active && !burst && cfg_q.edge_sel && !rise && $stable(cfg_q)
      |=> $stable(serial_tx)) else $error("edge 1 tx moved off rising edge");
   // A slot start may reload the count on its launch edge
   chk_sample_edge_norm: assert property (@(posedge mclk) disable iff (!rst_n) // RQ4
      clk_en && active && !burst && !cfg_q.edge_sel && !rise && !(strb_edge && launch)
      |=> $stable(cnt_q) || st_q != voice_port_pkg::ST_SHIFT)
      else $error("normal sample off rising edge");
   chk_burst_sample: assert property (@(posedge mclk) disable iff (!rst_n) // RQ13
      clk_en && active && burst && st_q == voice_port_pkg::ST_SHIFT && !fall
      && !(strb_rise && launch) |=> $stable(sh_rx_q)) else $error("burst sample off falling edge");
   chk_burst_len: assert property (@(posedge mclk) disable iff (!rst_n) // RQ11
      in_valid |-> burst ? (cnt_q == 6'd15) : 1'b1) else $error("burst word not 16 bits");
   chk_fill_bound: assert property (@(posedge mclk) disable iff (!rst_n)
      fill_q <= 2'h2) else $error("buffer overfilled");
   cov_word_rx: cover property (@(posedge mclk) disable iff (!rst_n) in_valid);
   cov_buf_full: cover property (@(posedge mclk) disable iff (!rst_n) fill_q == 2'h2);
   cov_overflow: cover property (@(posedge mclk) disable iff (!rst_n) $rose(ovf_q));
   // Scenario covers for burst skipping and full-width words
   cov_burst_skip: cover property (@(posedge mclk) disable iff (!rst_n)
      st_q == voice_port_pkg::ST_SKIP);
   cov_wide_word: cover property (@(posedge mclk) disable iff (!rst_n)
      in_valid && nbits == 7'd32);
   // Every taken request is answered in the next cycle
   chk_ack_answers: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && wb_cyc_i && wb_stb_i && !ack_q |=> wb_ack_o)
      else $error("request not acknowledged");
   // A port that is not a slave rests with a low tx
   chk_off_idle: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
      clk_en && !active |=> st_q == voice_port_pkg::ST_IDLE && !serial_tx)
      else $error("engine busy while not slave");
   // No word is gathered while the port is off
   chk_off_no_word: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
      clk_en && !active |-> !in_valid)
      else $error("word pushed while not slave");
   // The slave drives its data line while active
   chk_oe_when_on: assert property (@(posedge mclk) disable iff (!rst_n) // RQ10
      clk_en && active |=> serial_tx_oe)
      else $error("tx not driven while slave");
   // The launched bit always equals the top of the transmit shifter
   chk_tx_tracks_shift: assert property (@(posedge mclk) disable iff (!rst_n) // RQ18
      clk_en && active && launch
      && (st_q == voice_port_pkg::ST_SHIFT || (burst ? strb_rise : strb_edge))
      |=> serial_tx == sh_tx_q[31]) else $error("tx bit not from shifter top");
   // A word that finds the buffer full raises the loss flag
   chk_loss_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && in_valid && !in_ready && !(out_valid && out_ready) |=> ovf_q)
      else $error("lost word not flagged");
   // The loss flag stays until software clears it
   chk_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && ovf_q && !(wr && wb_adr_i == voice_port_pkg::STATUS_OFS && wb_dat_i[2])
      |=> ovf_q) else $error("loss flag dropped by itself");
   // A clear without a new loss lowers the flag
   chk_flag_clears: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && wr && wb_adr_i == voice_port_pkg::STATUS_OFS && wb_dat_i[2]
      && !(in_valid && !in_ready && !(out_valid && out_ready)) |=> !ovf_q)
      else $error("loss flag not cleared");
   // A push alone raises the fill level by one
   chk_push_fill: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && in_valid && in_ready && !(out_valid && out_ready)
      |=> fill_q == $past(fill_q) + 2'h1) else $error("push did not fill");
   // A pop alone lowers the fill level by one
   chk_pop_fill: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && out_valid && out_ready && !in_valid
      |=> fill_q == $past(fill_q) - 2'h1) else $error("pop did not drain");
   // A pop returns the oldest word
   chk_read_oldest: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && out_valid && out_ready |=> wb_dat_o == rxw_q)
      else $error("read not oldest word");
   // Reading an empty buffer returns zero
   chk_empty_read: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && rd && wb_adr_i == voice_port_pkg::RXW_OFS && !out_valid
      |=> wb_dat_o == 32'h0) else $error("empty read not zero");
   // Status shows whether a word was waiting when read
   chk_status_avail: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && rd && wb_adr_i == voice_port_pkg::STATUS_OFS
      |=> wb_dat_o[0] == rx_new_q) else $error("status avail bit wrong");
endmodule

// ===== codec_model.sv
// Behavioural codec that masters the voice link clock and strobe
`timescale 1ns/1ps
module codec_model
(
   output logic      bit_clk,
   output logic      word_align_strobe,
   output logic      serial_rx,
   input  wire logic serial_tx,
   input  wire logic serial_tx_oe
);
   logic [31:0] got_q[$];
   logic        oe_seen;
   logic        lr;
   // Idle levels at time zero
   initial
   begin
      bit_clk = 1'b0;
      word_align_strobe = 1'b0;
      serial_rx = 1'b0;
      oe_seen = 1'b0;
      lr = 1'b1;
   end
   // Parks the clock on its sample level so the next edge is a launch edge
   task automatic prep(input logic launch_rise, input logic strobe_idle);
      lr = launch_rise;
      bit_clk = ~launch_rise;
      word_align_strobe = strobe_idle;
   endtask
   // One slot per word; clock stands still once the slots are done
   task automatic run(input logic burst, input int nb, input int len,
                      input logic [31:0] rxw[$], input logic keep);
      logic [31:0] sh;
      sh = 32'h0;
      #3; // Keeps link edges clear of the system clock edges
      for (int s = 0; s < rxw.size(); s++)
      begin
         for (int b = 0; b < len; b++)
         begin
            bit_clk = lr;
            if (b == 0)
               word_align_strobe = burst ? 1'b1 : s[0];
            else if (burst)
               word_align_strobe = 1'b0;
            serial_rx = (b < nb) ? rxw[s][nb-1-b] : ~serial_rx;
            #80;
            bit_clk = ~lr;
            sh = {sh[30:0], serial_tx};
            oe_seen = oe_seen | serial_tx_oe;
            if (keep && b == nb - 1)
               got_q.push_back(nb == 32 ? sh : sh & ((32'h1 << nb) - 1));
            #80;
         end
      end
   endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the slave voice serial port
`timescale 1ns/1ps
module testbench;
   localparam logic NORM = voice_port_pkg::FMT_NORM;
   localparam logic BURST = voice_port_pkg::FMT_BURST;
   logic        mclk;
   logic        rst_n;
   logic        cyc;
   logic        we;
   logic [3:0]  adr;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic        bclk;
   logic        strb;
   logic        rx;
   logic        tx;
   logic        oe;
   logic [31:0] exp_q[$];
   logic [31:0] rxw[$];
   logic [31:0] txw;
   int          err_total;
   int          check_count;

   voice_serial_port_slave dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .bit_clk(bclk), .word_align_strobe(strb),
      .serial_rx(rx), .serial_tx(tx), .serial_tx_oe(oe));
   codec_model codec_u (.bit_clk(bclk), .word_align_strobe(strb), .serial_rx(rx),
      .serial_tx(tx), .serial_tx_oe(oe));

   // System clock
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Oldest expectation against a result
   task automatic cmp(input logic [31:0] got);
      logic [31:0] e;
      e = exp_q.pop_front();
      check_count++;
      if (got !== e)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   // Read data is compared at the edge that carries ack
   always @(posedge mclk)
      if (ack === 1'b1 && we === 1'b0)
         cmp(rdat);
   // Words heard by the codec
   initial
      forever
      begin
         wait (codec_u.got_q.size() > 0);
         cmp(codec_u.got_q.pop_front());
      end
   // Classic single cycle, held until ack
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
         @(posedge mclk);
      while (ack !== 1'b1);
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask
   function automatic logic [31:0] cfg(input logic en, input logic ck, input logic f,
                                       input logic [2:0] w, input logic e);
      cfg = {23'h0, e, w, f, ck, voice_port_pkg::PORT_ONE, en};
   endfunction
   // Frames of ns slots; at most two received words are read back
   task automatic frame(input logic f, input logic [2:0] w, input logic e, input int nb,
                        input int ns);
      logic [31:0] m;
      m = (nb == 32) ? 32'hffff_ffff : (32'h1 << nb) - 1;
      txw = $urandom();
      rxw = {};
      repeat (ns) rxw.push_back($urandom() & m);
      xfer(1'b1, voice_port_pkg::CTRL_OFS, 32'h0);
      codec_u.prep(f ? e : 1'b1, f);
      xfer(1'b1, voice_port_pkg::TXW_OFS, txw);
      xfer(1'b1, voice_port_pkg::CTRL_OFS, cfg(1'b1, 1'b0, f, w, e));
      foreach (rxw[i]) exp_q.push_back(txw & m);
      codec_u.oe_seen = 1'b0;
      codec_u.run(~f, nb, f ? nb : 48, rxw, 1'b1);
      exp_q.push_back(32'h1);
      cmp(32'(codec_u.oe_seen));
      @(posedge mclk);
      for (int i = 0; i < 2 && i < ns; i++) rd(voice_port_pkg::RXW_OFS, rxw[i]);
   endtask
   // Main sequence
   initial
   begin
      void'($urandom(32'h68e409a2));
      rst_n = 1'b0;
      cyc = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      wdat = 32'h0;
      err_total = 0;
      check_count = 0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(voice_port_pkg::CTRL_OFS, voice_port_pkg::CTRL_RESET);
      rd(voice_port_pkg::STATUS_OFS, 32'h0);
      xfer(1'b1, 4'h2, 32'hffff_ffff);
      rd(4'h2, 32'h0);
      rd(voice_port_pkg::RXW_OFS, 32'h0);
      for (int i = 0; i < 2; i++)
      begin
         codec_u.prep(1'b0, 1'b1);
         xfer(1'b1, voice_port_pkg::CTRL_OFS, cfg(1'(i), 1'(i), NORM, 3'h0, 1'b0));
         codec_u.oe_seen = 1'b0;
         rxw = {32'h1234, 32'h5678};
         codec_u.run(1'b0, 16, 16, rxw, 1'b0);
         @(posedge mclk);
         exp_q.push_back(32'h0);
         cmp(32'(codec_u.oe_seen));
         rd(voice_port_pkg::RXW_OFS, 32'h0);
      end
      frame(BURST, voice_port_pkg::WID_16, 1'b0, 16, 1);
      frame(BURST, voice_port_pkg::WID_16, 1'b1, 16, 1);
      frame(NORM, voice_port_pkg::WID_16, 1'b1, 16, 2);
      frame(NORM, voice_port_pkg::WID_24, 1'b0, 24, 2);
      frame(NORM, voice_port_pkg::WID_32, 1'b1, 32, 2);
      frame(NORM, voice_port_pkg::WID_16, 1'b0, 16, 4);
      xfer(1'b1, voice_port_pkg::CTRL_OFS, 32'h0);
      rd(voice_port_pkg::STATUS_OFS, 32'h4);
      xfer(1'b1, voice_port_pkg::STATUS_OFS, 32'h4);
      rd(voice_port_pkg::STATUS_OFS, 32'h0);
      rd(voice_port_pkg::RXW_OFS, 32'h0);
      repeat (4) @(posedge mclk);
      give_verdict();
   end
   // Cuts a hang short
   initial
   begin
      #800_000;
      err_total++;
      give_verdict();
   end
endmodule
